// [tmr2_ctrl.sv]
`timescale 1ns/100ps
`include "tmr2_cfg.svh"
// Function
// - overflow sets flag, held until software clears
// - no overflow flag while a baud select set
// - receive baud tick from here when selected
// - transmit baud tick from here when selected
// - enabled trigger falls cause capture or reload while running, except in baud mode
// - timer ticks per machine cycle (per state in baud mode), counter on falls
// - capture select makes trigger fall capture
// - reload select reloads on overflow and trigger
// - baud mode forces reload, ignores capture select
// - mode decode from run, baud, capture bits
// - low half carry advances high half
// - accepted trigger sets external flag, interrupts
// - capture copies both halves, counting continues
// - overflow past all ones loads capture value, except in capture mode
module tmr2_ctrl
  import tmr2_pkg::*;
#(
  parameter int ADDR_W = 3,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic count_input_pin,
  input wire logic ext_trigger_pin,
  input wire logic timer1_ovf,
  output logic rx_baud_tick,
  output logic tx_baud_tick,
  output logic irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tmr2_ctrl_s ctrl_ff, nxt_ctrl;
  logic [7:0] cnt_lo_ff, nxt_cnt_lo;
  logic [7:0] cnt_hi_ff, nxt_cnt_hi;
  logic [7:0] cap_lo_ff, nxt_cap_lo;
  logic [7:0] cap_hi_ff, nxt_cap_hi;
  logic [1:0] mask_ff, nxt_mask;
  logic clk_mode_ff, nxt_clk_mode;
  logic [3:0] presc_ff, nxt_presc;
  logic [2:0] cnt_sync_ff, nxt_cnt_sync;
  logic [2:0] trg_sync_ff, nxt_trg_sync;
  logic [DATA_W-1:0] rdata_ff, nxt_rdata;
  logic irq_ff, nxt_irq;
  logic rx_tick_ff, nxt_rx_tick;
  logic tx_tick_ff, nxt_tx_tick;

  tmr2_mode_e mode;
  logic baud, tick, mc_tick, fast_tick, cnt_fall, trg_fall, trig;
  logic carry_lo, ovf, reload, capture;
  logic set_ovf, set_ext;
  logic [3:0] div;
  logic [1:0] flags;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // sync stages 1 and 2 feed stage 3; the edge looks at 2 and 3 only
  function automatic logic fall(input logic [2:0] s);
    fall = s[2] & ~s[1];
  endfunction

  function automatic logic [7:0] inc8(input logic [7:0] v);
    inc8 = v + 8'h01;
  endfunction

  function automatic logic wr_hit(input logic wr, input logic [ADDR_W-1:0] a,
                                  input logic [2:0] ofs);
    wr_hit = wr && (a == ADDR_W'(ofs));
  endfunction

  // ---------------------------------------------------------------
  // mode, pin sync and prescaler
  // ---------------------------------------------------------------
  always_comb begin
    baud = ctrl_ff.rx_clock_select | ctrl_ff.tx_clock_select;
    if (!ctrl_ff.run_control) begin
      mode = TMR2_OFF;
    end else if (baud) begin
      mode = TMR2_BAUD_GEN;
    end else if (ctrl_ff.capture_reload_select) begin
      mode = TMR2_CAPTURE;
    end else begin
      mode = TMR2_AUTO_RELOAD;
    end

    nxt_cnt_sync = {cnt_sync_ff[1:0], count_input_pin};
    nxt_trg_sync = {trg_sync_ff[1:0], ext_trigger_pin};
    cnt_fall = fall(cnt_sync_ff);
    trg_fall = fall(trg_sync_ff);

    // free-running prescaler; baud mode counts at the state rate
    div = clk_mode_ff ? `TMR2_DIV_6CLK : `TMR2_DIV_12CLK;
    mc_tick = (presc_ff == (div - `TMR2_PRESC_ONE));
    nxt_presc = mc_tick ? `TMR2_PRESC_RST : presc_ff + `TMR2_PRESC_ONE;
    fast_tick = clk_mode_ff | presc_ff[0];

    if (ctrl_ff.timer_counter_select) begin
      tick = cnt_fall;
    end else begin
      tick = baud ? fast_tick : mc_tick;
    end
    tick = tick & (mode != TMR2_OFF);
  end

  // ---------------------------------------------------------------
  // counter halves
  // ---------------------------------------------------------------
  always_comb begin
    carry_lo = (cnt_lo_ff == `TMR2_BYTE_MAX);
    ovf = tick & carry_lo & (cnt_hi_ff == `TMR2_BYTE_MAX);

    // trigger is accepted whenever enabled; its flag is set even in baud mode
    trig = ctrl_ff.ext_trigger_enable & trg_fall;
    capture = trig & (mode == TMR2_CAPTURE);
    reload = (ovf & (mode != TMR2_CAPTURE)) |
             (trig & (mode == TMR2_AUTO_RELOAD));

    nxt_cnt_lo = cnt_lo_ff;
    nxt_cnt_hi = cnt_hi_ff;
    if (tick) begin
      nxt_cnt_lo = inc8(cnt_lo_ff);
      if (carry_lo) begin
        nxt_cnt_hi = inc8(cnt_hi_ff);
      end
    end
    if (reload) begin
      nxt_cnt_lo = cap_lo_ff;
      nxt_cnt_hi = cap_hi_ff;
    end
    // a software write lands over counting; stop the timer first
    if (wr_hit(reg_wr, reg_addr, `TMR2_OFS_CNT_LO)) begin
      nxt_cnt_lo = reg_wdata[7:0];
    end
    if (wr_hit(reg_wr, reg_addr, `TMR2_OFS_CNT_HI)) begin
      nxt_cnt_hi = reg_wdata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // capture halves
  // ---------------------------------------------------------------
  always_comb begin
    nxt_cap_lo = cap_lo_ff;
    nxt_cap_hi = cap_hi_ff;
    if (wr_hit(reg_wr, reg_addr, `TMR2_OFS_CAP_LO)) begin
      nxt_cap_lo = reg_wdata[7:0];
    end
    if (wr_hit(reg_wr, reg_addr, `TMR2_OFS_CAP_HI)) begin
      nxt_cap_hi = reg_wdata[7:0];
    end
    // hardware capture beats a same-cycle write of the capture halves
    if (capture) begin
      nxt_cap_lo = cnt_lo_ff;
      nxt_cap_hi = cnt_hi_ff;
    end
  end

  // ---------------------------------------------------------------
  // control and interrupt flags
  // ---------------------------------------------------------------
  always_comb begin
    set_ovf = ovf & ~baud;
    set_ext = trig;

    nxt_ctrl = ctrl_ff;
    if (wr_hit(reg_wr, reg_addr, `TMR2_OFS_CTRL)) begin
      nxt_ctrl = tmr2_ctrl_s'(reg_wdata[7:0]);
      // flags can only be cleared by software, never set
      nxt_ctrl.overflow_flag = ctrl_ff.overflow_flag & reg_wdata[`TMR2_BIT_OVF];
      nxt_ctrl.external_flag = ctrl_ff.external_flag & reg_wdata[`TMR2_BIT_EXT];
    end
    if (wr_hit(reg_wr, reg_addr, `TMR2_OFS_INT_STAT)) begin
      nxt_ctrl.overflow_flag = ctrl_ff.overflow_flag & ~reg_wdata[`TMR2_IBIT_OVF];
      nxt_ctrl.external_flag = ctrl_ff.external_flag & ~reg_wdata[`TMR2_IBIT_EXT];
    end
    nxt_ctrl.overflow_flag = nxt_ctrl.overflow_flag | set_ovf;
    nxt_ctrl.external_flag = nxt_ctrl.external_flag | set_ext;

    nxt_mask = mask_ff;
    if (wr_hit(reg_wr, reg_addr, `TMR2_OFS_INT_MASK)) begin
      nxt_mask = reg_wdata[1:0];
    end
    nxt_clk_mode = clk_mode_ff;
    if (wr_hit(reg_wr, reg_addr, `TMR2_OFS_CLK_MODE)) begin
      nxt_clk_mode = reg_wdata[0];
    end
  end

  // ---------------------------------------------------------------
  // bus read and outputs
  // ---------------------------------------------------------------
  always_comb begin
    flags = {ctrl_ff.external_flag, ctrl_ff.overflow_flag};
    nxt_irq = |(flags & mask_ff);

    // the serial port itself decides whether it is in mode 1 or 3
    nxt_rx_tick = ctrl_ff.rx_clock_select ? (ovf & baud) : timer1_ovf;
    nxt_tx_tick = ctrl_ff.tx_clock_select ? (ovf & baud) : timer1_ovf;

    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_W'(`TMR2_OFS_CTRL): nxt_rdata = DATA_W'(ctrl_ff);
        ADDR_W'(`TMR2_OFS_CNT_LO): nxt_rdata = DATA_W'(cnt_lo_ff);
        ADDR_W'(`TMR2_OFS_CNT_HI): nxt_rdata = DATA_W'(cnt_hi_ff);
        ADDR_W'(`TMR2_OFS_CAP_LO): nxt_rdata = DATA_W'(cap_lo_ff);
        ADDR_W'(`TMR2_OFS_CAP_HI): nxt_rdata = DATA_W'(cap_hi_ff);
        ADDR_W'(`TMR2_OFS_INT_STAT): nxt_rdata = DATA_W'(flags);
        ADDR_W'(`TMR2_OFS_INT_MASK): nxt_rdata = DATA_W'(mask_ff);
        ADDR_W'(`TMR2_OFS_CLK_MODE): nxt_rdata = DATA_W'(clk_mode_ff);
        default: nxt_rdata = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers: pin sync and prescaler
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      presc_ff <= `TMR2_PRESC_RST;
      // pins idle high, so a pin held low at release reads as a fall
      cnt_sync_ff <= `TMR2_SYNC_RST;
      trg_sync_ff <= `TMR2_SYNC_RST;
    end else begin
      presc_ff <= nxt_presc;
      cnt_sync_ff <= nxt_cnt_sync;
      trg_sync_ff <= nxt_trg_sync;
    end
  end

  // ---------------------------------------------------------------
  // registers: counter halves
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_lo_ff <= `TMR2_BYTE_RST;
      cnt_hi_ff <= `TMR2_BYTE_RST;
    end else begin
      cnt_lo_ff <= nxt_cnt_lo;
      cnt_hi_ff <= nxt_cnt_hi;
    end
  end

  // ---------------------------------------------------------------
  // registers: capture halves
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cap_lo_ff <= `TMR2_BYTE_RST;
      cap_hi_ff <= `TMR2_BYTE_RST;
    end else begin
      cap_lo_ff <= nxt_cap_lo;
      cap_hi_ff <= nxt_cap_hi;
    end
  end

  // ---------------------------------------------------------------
  // registers: control and interrupt flags
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= tmr2_ctrl_s'(`TMR2_CTRL_RST);
      mask_ff <= `TMR2_MASK_RST;
      clk_mode_ff <= `TMR2_CLKMODE_RST;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      clk_mode_ff <= nxt_clk_mode;
    end
  end

  // ---------------------------------------------------------------
  // registers: bus read and outputs
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= '0;
      irq_ff <= 1'b0;
      rx_tick_ff <= 1'b0;
      tx_tick_ff <= 1'b0;
    end else begin
      rdata_ff <= nxt_rdata;
      irq_ff <= nxt_irq;
      rx_tick_ff <= nxt_rx_tick;
      tx_tick_ff <= nxt_tx_tick;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = irq_ff;
  assign rx_baud_tick = rx_tick_ff;
  assign tx_baud_tick = tx_tick_ff;

endmodule

// [tmr2_cfg.svh]
`ifndef TMR2_CFG_SVH
`define TMR2_CFG_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define TMR2_OFS_CTRL 3'h0
`define TMR2_OFS_CNT_LO 3'h1
`define TMR2_OFS_CNT_HI 3'h2
`define TMR2_OFS_CAP_LO 3'h3
`define TMR2_OFS_CAP_HI 3'h4
`define TMR2_OFS_INT_STAT 3'h5
`define TMR2_OFS_INT_MASK 3'h6
`define TMR2_OFS_CLK_MODE 3'h7

// ---------------------------------------------------------------
// field positions and reset values
// ---------------------------------------------------------------
`define TMR2_BIT_OVF 7
`define TMR2_BIT_EXT 6
`define TMR2_IBIT_OVF 0
`define TMR2_IBIT_EXT 1
`define TMR2_CTRL_RST 8'h00
`define TMR2_BYTE_RST 8'h00
`define TMR2_BYTE_MAX 8'hFF
`define TMR2_MASK_RST 2'h0
`define TMR2_CLKMODE_RST 1'h0
`define TMR2_SYNC_RST 3'h7

// ---------------------------------------------------------------
// prescaler counts in oscillator cycles
// ---------------------------------------------------------------
`define TMR2_DIV_6CLK 4'h6
`define TMR2_DIV_12CLK 4'hC
`define TMR2_PRESC_RST 4'h0
`define TMR2_PRESC_ONE 4'h1

`endif

// [tmr2_pkg.sv]
package tmr2_pkg;

  // ---------------------------------------------------------------
  // control register layout, msb first
  // ---------------------------------------------------------------
  typedef struct packed {
    logic overflow_flag;
    logic external_flag;
    logic rx_clock_select;
    logic tx_clock_select;
    logic ext_trigger_enable;
    logic run_control;
    logic timer_counter_select;
    logic capture_reload_select;
  } tmr2_ctrl_s;

  typedef enum logic [1:0] {
    TMR2_OFF = 2'b00,
    TMR2_AUTO_RELOAD = 2'b01,
    TMR2_CAPTURE = 2'b10,
    TMR2_BAUD_GEN = 2'b11
  } tmr2_mode_e;

endpackage

// [tmr2_ctrl_props.sv]
`timescale 1ns/100ps
`include "tmr2_cfg.svh"
module tmr2_props (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic ext_trigger_pin,
  input wire logic timer1_ovf,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  input wire logic irq
);
  // shadow of rx, tx, trigger enable, run and mask
  logic [3:0] cfg_ff;
  logic [1:0] mask_ff;
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cfg_ff <= 4'h0;
      mask_ff <= 2'h0;
    end else if (reg_wr && reg_addr == `TMR2_OFS_CTRL) begin
      cfg_ff <= reg_wdata[5:2];
    end else if (reg_wr && reg_addr == `TMR2_OFS_INT_MASK) begin
      mask_ff <= reg_wdata[1:0];
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence trig_fall;
    $fell(ext_trigger_pin) && cfg_ff[1];
  endsequence
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_rx_source: assert property (
    !$past(cfg_ff[3]) |-> rx_baud_tick == $past(timer1_ovf)) else $error("rx tick");
  a_tx_source: assert property (
    !$past(cfg_ff[2]) |-> tx_baud_tick == $past(timer1_ovf)) else $error("tx tick");
  a_stop_quiet: assert property (
    $past(cfg_ff) == 4'h8 && $past(cfg_ff, 2) == 4'h8 |-> !rx_baud_tick)
    else $error("tick while stopped");
  a_irq_masked: assert property (
    mask_ff == 2'h0 && $past(mask_ff) == 2'h0 |-> !irq) else $error("masked irq");
  a_trig_irq: assert property (
    trig_fall ##0 mask_ff[1] |-> ##[2:6] irq) else $error("no trigger irq");
  a_trig_ignored: assert property (
    $fell(ext_trigger_pin) && !cfg_ff[1] && mask_ff == 2'h2 && $past(mask_ff) == 2'h2
    && !irq |-> (!irq) [*6]) else $error("trigger not ignored");
  a_baud_noovf: assert property (
    $past(cfg_ff[3:2]) != 2'h0 && cfg_ff[3:2] != 2'h0 && mask_ff == 2'h1
    && $past(mask_ff) == 2'h1 && !irq |=> !irq) else $error("ovf in baud mode");
  a_flag_sticky: assert property (
    irq && !$past(reg_wr) |=> irq) else $error("flag lost");
endmodule
bind tmr2_ctrl tmr2_props u_props (.ref_clk(ref_clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .ext_trigger_pin(ext_trigger_pin), .timer1_ovf(timer1_ovf),
  .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick), .irq(irq));

// [tmr2_partner.sv]
`timescale 1ns/100ps
module tmr2_partner (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic trig_req,
  input wire logic cnt_req,
  input wire logic t1_en,
  input wire logic rx_baud_tick,
  input wire logic tx_baud_tick,
  output logic ext_trigger_pin,
  output logic count_input_pin,
  output logic timer1_ovf,
  output logic [15:0] rx_n,
  output logic [15:0] tx_n,
  output logic [15:0] t1_n
);
  // pins idle high; a fall is held 4 cycles so the sync stages see it
  logic [2:0] trig_ff;
  logic [2:0] cnt_ff;
  logic [3:0] gap_ff;
  assign ext_trigger_pin = (trig_ff == 3'h0);
  assign count_input_pin = (cnt_ff == 3'h0);
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      trig_ff <= 3'h0;
      cnt_ff <= 3'h0;
      gap_ff <= 4'h0;
      timer1_ovf <= 1'b0;
      rx_n <= 16'h0000;
      tx_n <= 16'h0000;
      t1_n <= 16'h0000;
    end else begin
      trig_ff <= trig_req ? 3'h4 : (trig_ff == 3'h0 ? 3'h0 : trig_ff - 3'h1);
      cnt_ff <= cnt_req ? 3'h4 : (cnt_ff == 3'h0 ? 3'h0 : cnt_ff - 3'h1);
      gap_ff <= (gap_ff == 4'h9) ? 4'h0 : gap_ff + 4'h1;
      timer1_ovf <= t1_en && gap_ff == 4'h9;
      t1_n <= t1_n + {15'h0000, timer1_ovf};
      rx_n <= rx_n + {15'h0000, rx_baud_tick};
      tx_n <= tx_n + {15'h0000, tx_baud_tick};
    end
  end
endmodule

// [tb_tmr2_ctrl.sv]
`timescale 1ns/100ps
`include "tmr2_cfg.svh"
module tb_tmr2_ctrl;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic trig_req = 1'b0;
  logic cnt_req = 1'b0;
  logic t1_en = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic count_input_pin, ext_trigger_pin, timer1_ovf, rx_baud_tick, tx_baud_tick, irq;
  logic [15:0] rx_n, tx_n, t1_n, r0, x0, q0;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  tmr2_ctrl DUT (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_input_pin(count_input_pin), .ext_trigger_pin(ext_trigger_pin),
    .timer1_ovf(timer1_ovf), .rx_baud_tick(rx_baud_tick), .tx_baud_tick(tx_baud_tick),
    .irq(irq));
  tmr2_partner u_far (.ref_clk(ref_clk), .reset(reset), .trig_req(trig_req),
    .cnt_req(cnt_req), .t1_en(t1_en), .rx_baud_tick(rx_baud_tick),
    .tx_baud_tick(tx_baud_tick), .ext_trigger_pin(ext_trigger_pin),
    .count_input_pin(count_input_pin), .timer1_ovf(timer1_ovf), .rx_n(rx_n),
    .tx_n(tx_n), .t1_n(t1_n));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic stop_test;
    if (errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, e});
  endtask
  // one falling edge on the trigger pin (t=1) or the count pin
  task automatic fall(input logic t);
    @(posedge ref_clk);
    trig_req <= t;
    cnt_req <= !t;
    @(posedge ref_clk);
    trig_req <= 1'b0;
    cnt_req <= 1'b0;
    repeat (10) @(posedge ref_clk);
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rd(3'(i), 8'h00);
    end
  endtask
  task automatic t_capture;
    wr(`TMR2_OFS_INT_MASK, 8'h02);
    wr(`TMR2_OFS_CTRL, 8'h01);
    fall(1'b1);
    rd(`TMR2_OFS_CTRL, 8'h01);
    wr(`TMR2_OFS_CNT_LO, 8'h34);
    wr(`TMR2_OFS_CNT_HI, 8'h12);
    // counter mode with an idle count pin keeps the count still for the capture
    wr(`TMR2_OFS_CTRL, 8'h0F);
    fall(1'b1);
    rd(`TMR2_OFS_CAP_LO, 8'h34);
    rd(`TMR2_OFS_CAP_HI, 8'h12);
    rd(`TMR2_OFS_CTRL, 8'h4F);
    chk({15'h0000, irq}, 16'h0001);
    wr(`TMR2_OFS_INT_STAT, 8'h02);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({15'h0000, irq}, 16'h0000);
  endtask
  task automatic t_reload;
    wr(`TMR2_OFS_CAP_LO, 8'hCD);
    wr(`TMR2_OFS_CAP_HI, 8'hAB);
    wr(`TMR2_OFS_CTRL, 8'h06);
    wr(`TMR2_OFS_CNT_LO, 8'hFF);
    wr(`TMR2_OFS_CNT_HI, 8'h00);
    fall(1'b0);
    rd(`TMR2_OFS_CNT_LO, 8'h00);
    rd(`TMR2_OFS_CNT_HI, 8'h01);
    wr(`TMR2_OFS_CNT_LO, 8'hFF);
    wr(`TMR2_OFS_CNT_HI, 8'hFF);
    fall(1'b0);
    rd(`TMR2_OFS_CNT_LO, 8'hCD);
    rd(`TMR2_OFS_CNT_HI, 8'hAB);
    rd(`TMR2_OFS_CTRL, 8'h86);
    wr(`TMR2_OFS_INT_MASK, 8'h01);
    repeat (2) @(posedge ref_clk);
    #1;
    chk({15'h0000, irq}, 16'h0001);
    wr(`TMR2_OFS_CTRL, 8'h02);
    rd(`TMR2_OFS_CTRL, 8'h02);
    fall(1'b0);
    rd(`TMR2_OFS_CNT_LO, 8'hCD);
    wr(`TMR2_OFS_CTRL, 8'h0E);
    wr(`TMR2_OFS_CNT_LO, 8'h11);
    fall(1'b1);
    rd(`TMR2_OFS_CNT_LO, 8'hCD);
  endtask
  // count and reload at all ones: every 12-clock baud tick (2 cycles) overflows
  // timer 1 runs only while the select is settled, so both counts see each pulse
  task automatic t_baud;
    wr(`TMR2_OFS_CAP_LO, 8'hFF);
    wr(`TMR2_OFS_CAP_HI, 8'hFF);
    wr(`TMR2_OFS_CNT_LO, 8'hFF);
    wr(`TMR2_OFS_CNT_HI, 8'hFF);
    for (int i = 0; i < 2; i++) begin
      r0 = rx_n;
      x0 = tx_n;
      q0 = t1_n;
      wr(`TMR2_OFS_CTRL, i ? 8'h15 : 8'h25);
      t1_en <= 1'b1;
      repeat (200) @(posedge ref_clk);
      wr(`TMR2_OFS_CTRL, i ? 8'h11 : 8'h21);
      t1_en <= 1'b0;
      rd(`TMR2_OFS_CTRL, i ? 8'h11 : 8'h21);
      repeat (3) @(posedge ref_clk);
      if (i == 0) begin
        chk(16'((rx_n - r0) inside {[16'd99:16'd103]}), 16'h0001);
        chk(tx_n - x0, t1_n - q0);
      end else begin
        chk(16'((tx_n - x0) inside {[16'd99:16'd103]}), 16'h0001);
        chk(rx_n - r0, t1_n - q0);
      end
    end
  endtask
  // a run window of whole prescaler periods gives an exact count
  task automatic t_timer;
    for (int i = 0; i < 2; i++) begin
      wr(`TMR2_OFS_CLK_MODE, 8'(i));
      wr(`TMR2_OFS_CTRL, 8'h00);
      wr(`TMR2_OFS_CNT_LO, 8'h00);
      wr(`TMR2_OFS_CNT_HI, 8'h00);
      repeat (16) @(posedge ref_clk);
      wr(`TMR2_OFS_CTRL, 8'h04);
      repeat (118) @(posedge ref_clk);
      wr(`TMR2_OFS_CTRL, 8'h00);
      rd(`TMR2_OFS_CNT_LO, i ? 8'h14 : 8'h0A);
      rd(`TMR2_OFS_CNT_HI, 8'h00);
      rd(`TMR2_OFS_CLK_MODE, 8'(i));
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_capture();
    t_reload();
    t_baud();
    t_timer();
    stop_test();
  end
endmodule
